// file: design/sld_pkg.sv
// Constants, colour codes and carrier types for the front-panel status encoder.
// Assumes one 200 MHz system clock and a simple strobe-based register port.
// Function
// - Backup running: stop LED and startup/power-fail LED show yellow.
// - Backup finished: run LED shows green.
// - Upgrade copy finished cleanly: ready LED steady green for at least ten seconds.
// - Upgrade copy running: ready LED steady yellow, never alternating.
// - After reset completes, stop LED flashes yellow at 2 Hz during power-up.
// - Upgrade complete: system-fault LED off, then automatic boot request, in run mode only.
// - Module held in reset by button or fan: display shows 8; heat enters fault hold and shows F.
// - Controller powered up: display shows 6.
// - Decimal point flashes while drive-unit communication runs.
// - Fault hold: all LEDs flicker red, display shows F.
// - Unhandled fault such as overtemperature enters fault hold, processor halted.
// - Permanent reset: ready LED alternates red/yellow at 2 Hz, display shows 8.
// - Permanent reset: processor held in reset, hardware in low-power condition.
// - Fault hold and permanent reset latch until power is cycled.
// - Port link LED steady green while a partner is physically connected.
// - Port activity LED flashes yellow while data moves on that port.
// - Network fault LED off while operating without error.
// - Network fault LED steady on for a bus fault.
// - Network fault LED flashes 2 Hz on device failure or configuration error; there is no configuration-error input here, only device_fail flashes it.
// - Sync LED off until locked, and whenever isochronous operation is unconfigured.
// - Configured but unlocked: generate a local substitute cycle clock.
// - Locked: sync LED steady if drives synchronized, else flashes at 2 Hz.
package sld_pkg;

  // Timing in milliseconds, and the clock rate that turns it into cycles.
  localparam int unsigned CLK_KHZ = 200000;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned FLICKER_HALF_MS = 25;
  localparam int unsigned COPY_HOLD_MS = 10000;
  localparam int unsigned SUBST_CYCLE_MS = 1;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam int unsigned FLICKER_HALF_CYC = FLICKER_HALF_MS * CLK_KHZ;
  localparam int unsigned COPY_HOLD_CYC = COPY_HOLD_MS * CLK_KHZ;
  localparam int unsigned SUBST_CYCLE_CYC = SUBST_CYCLE_MS * CLK_KHZ;
  localparam int unsigned NUM_PORTS = 2;

  // Register byte addresses.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CMD = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;

  // Command bit positions in the command register.
  localparam int CMD_COPY_OK = 0;
  localparam int CMD_UPG_DONE = 1;
  localparam int CMD_FAULT = 2;
  localparam int CMD_PERM = 3;

  // LED colour codes.
  typedef logic [1:0] sld_colour_t;
  localparam sld_colour_t COL_OFF = 2'h0;
  localparam sld_colour_t COL_GREEN = 2'h1;
  localparam sld_colour_t COL_YELLOW = 2'h2;
  localparam sld_colour_t COL_RED = 2'h3;

  // Seven-segment patterns, bit order g..a.
  localparam logic [6:0] SEG_BLANK = 7'h00;
  localparam logic [6:0] SEG_EIGHT = 7'h7f;
  localparam logic [6:0] SEG_SIX = 7'h7d;
  localparam logic [6:0] SEG_F = 7'h71;

  // Software control bits.
  typedef struct packed {
    logic iso_cfg;
    logic drv_comm;
    logic powered;
    logic upg_busy;
    logic copy_busy;
    logic backup_done;
    logic backup_run;
  } sld_ctrl_t;
  localparam sld_ctrl_t CTRL_RESET = '0;

  // The five front-panel LEDs.
  typedef struct packed {
    sld_colour_t rdy;
    sld_colour_t run;
    sld_colour_t stop;
    sld_colour_t startup_power_fail_led;
    sld_colour_t system_fault_led;
  } sld_panel_t;

  typedef struct packed {
    logic dp;
    logic [6:0] seg;
  } sld_seg_t;

  typedef enum logic [1:0] {MODE_POWERUP, MODE_RUN, MODE_FAULT, MODE_PERM} sld_mode_t;

endpackage

// file: design/sld_encoder.sv
// Front-panel status encoder: LEDs, seven-segment display and network LEDs.
// Assumes asynchronous pins are synchronised here and software uses the strobe port.
`timescale 1ns/1ps
module sld_encoder #(
  parameter int unsigned NPORTS = sld_pkg::NUM_PORTS,
  parameter int unsigned BLINK_HALF = sld_pkg::BLINK_HALF_CYC,
  parameter int unsigned FLICKER_HALF = sld_pkg::FLICKER_HALF_CYC,
  parameter int unsigned COPY_HOLD = sld_pkg::COPY_HOLD_CYC,
  parameter int unsigned SUBST_CYCLE = sld_pkg::SUBST_CYCLE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic reset_button,
  input wire logic fan_fault,
  input wire logic overtemp,
  input wire logic bus_fault,
  input wire logic device_fail,
  input wire logic cycle_locked,
  input wire logic drives_synced,
  input wire logic ext_cycle,
  input wire logic [NPORTS-1:0] port_link,
  input wire logic [NPORTS-1:0] port_busy,
  output sld_pkg::sld_panel_t panel,
  output sld_pkg::sld_seg_t display,
  output logic [NPORTS-1:0] link_led,
  output logic [NPORTS-1:0] port_activity_led,
  output logic net_fault_led,
  output logic sync_led,
  output logic cycle_tick,
  output logic cpu_halt,
  output logic cpu_reset,
  output logic low_power,
  output logic boot_req
);
  import sld_pkg::*;

  localparam int SW = 8 + 2 * NPORTS;

  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic cyc_d_reg;
  logic [31:0] slow_cnt_reg;
  logic [31:0] fast_cnt_reg;
  logic [31:0] copy_cnt_reg;
  logic [31:0] subst_cnt_reg;
  logic slow_ph_reg;
  logic fast_ph_reg;
  logic upg_fin_reg;
  sld_ctrl_t ctrl_reg;
  sld_mode_t mode_reg;
  sld_panel_t panel_reg;
  sld_panel_t panel_next;
  sld_seg_t display_reg;
  sld_seg_t display_next;
  logic [31:0] rdata_reg;
  logic [NPORTS-1:0] link_reg;
  logic [NPORTS-1:0] act_reg;
  logic net_fault_reg;
  logic sync_reg;
  logic tick_reg;
  logic halt_reg;
  logic cpu_rst_reg;
  logic low_pwr_reg;
  logic boot_reg;
  logic boot_arm_reg;

  // Synchronised views; only the second stage is ever read.
  logic rst_btn_s, fan_s, hot_s, bus_flt_s, dev_fail_s, locked_s, drv_sync_s, cyc_s;
  logic [NPORTS-1:0] link_s;
  logic [NPORTS-1:0] busy_s;
  logic cmd_wr;
  logic hold_s;
  logic copy_ok_wr;
  sld_ctrl_t ctrl_wdata;

  assign {rst_btn_s, fan_s, hot_s, bus_flt_s, dev_fail_s, locked_s, drv_sync_s, cyc_s,
          link_s, busy_s} = sync2_reg;
  assign cmd_wr = wr_stb && (addr == ADDR_CMD);
  assign hold_s = rst_btn_s || fan_s || hot_s;
  assign copy_ok_wr = cmd_wr && wdata[CMD_COPY_OK];
  assign ctrl_wdata = sld_ctrl_t'(wdata[$bits(sld_ctrl_t)-1:0]);

  // Map a colour to the flashing colour or off, used by several LEDs.
  function automatic sld_colour_t flash(input sld_colour_t c, input logic ph);
    flash = ph ? c : COL_OFF;
  endfunction

  // Two-stage synchroniser for every pin that arrives from outside.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {reset_button, fan_fault, overtemp, bus_fault, device_fail, cycle_locked,
                    drives_synced, ext_cycle, port_link, port_busy};
      sync2_reg <= sync1_reg;
    end
  end

  // Shared blink and flicker phases keep every LED of one pattern in step.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt_reg <= '0;
      slow_ph_reg <= 1'b0;
    end else if (slow_cnt_reg == 32'(BLINK_HALF - 1)) begin
      slow_cnt_reg <= '0;
      slow_ph_reg <= !slow_ph_reg;
    end else begin
      slow_cnt_reg <= slow_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_cnt_reg <= '0;
      fast_ph_reg <= 1'b0;
    end else if (fast_cnt_reg == 32'(FLICKER_HALF - 1)) begin
      fast_cnt_reg <= '0;
      fast_ph_reg <= !fast_ph_reg;
    end else begin
      fast_cnt_reg <= fast_cnt_reg + 32'h1;
    end
  end

  // Software control register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_stb && addr == ADDR_CTRL) begin
      ctrl_reg <= ctrl_wdata;
    end
  end

  // Operating mode. Fault hold and permanent reset have no exit but power removal,
  // so a misbehaving program cannot bring a halted processor back by itself.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= MODE_POWERUP;
    end else begin
      case (mode_reg)
        MODE_POWERUP, MODE_RUN: begin
          if (cmd_wr && wdata[CMD_PERM]) begin
            mode_reg <= MODE_PERM;
          end else if (hot_s || (cmd_wr && wdata[CMD_FAULT])) begin
            mode_reg <= MODE_FAULT;
          end else if (ctrl_reg.powered) begin
            mode_reg <= MODE_RUN;
          end
        end
        MODE_FAULT: mode_reg <= MODE_FAULT;
        MODE_PERM: mode_reg <= MODE_PERM;
        default: mode_reg <= MODE_FAULT;
      endcase
    end
  end

  // Ten-second hold of the clean-copy indication, restarted by each report.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      copy_cnt_reg <= '0;
    end else if (copy_ok_wr) begin
      copy_cnt_reg <= 32'(COPY_HOLD);
    end else if (copy_cnt_reg != 32'h0) begin
      copy_cnt_reg <= copy_cnt_reg - 32'h1;
    end
  end

  // Upgrade finish: the fault LED goes dark, a one-cycle boot request follows in run mode only.
  // The request is armed one cycle so that it never leaves ahead of the dark LED.
  // A new upgrade start in the same cycle as the finish report loses to the report.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      upg_fin_reg <= 1'b0;
      boot_reg <= 1'b0;
      boot_arm_reg <= 1'b0;
    end else begin
      boot_reg <= boot_arm_reg && (mode_reg == MODE_RUN);
      boot_arm_reg <= 1'b0;
      if (cmd_wr && wdata[CMD_UPG_DONE]) begin
        upg_fin_reg <= 1'b1;
        boot_arm_reg <= 1'b1;
      end else if (wr_stb && addr == ADDR_CTRL && ctrl_wdata.upg_busy) begin
        upg_fin_reg <= 1'b0;
      end
    end
  end

  // Panel LED decode with latched states first.
  always_comb begin
    panel_next = '0;
    display_next = '0;
    case (mode_reg)
      MODE_FAULT: begin
        panel_next.rdy = flash(COL_RED, fast_ph_reg);
        panel_next.run = flash(COL_RED, fast_ph_reg);
        panel_next.stop = flash(COL_RED, fast_ph_reg);
        panel_next.startup_power_fail_led = flash(COL_RED, fast_ph_reg);
        panel_next.system_fault_led = flash(COL_RED, fast_ph_reg);
        display_next.seg = SEG_F;
      end
      MODE_PERM: begin
        panel_next.rdy = slow_ph_reg ? COL_RED : COL_YELLOW;
        display_next.seg = SEG_EIGHT;
      end
      default: begin
        if (mode_reg == MODE_POWERUP) begin
          panel_next.stop = flash(COL_YELLOW, slow_ph_reg);
        end
        if (copy_cnt_reg != 32'h0) begin
          panel_next.rdy = COL_GREEN;
        end else if (ctrl_reg.copy_busy) begin
          panel_next.rdy = COL_YELLOW;
        end
        if (ctrl_reg.backup_run) begin
          panel_next.stop = COL_YELLOW;
          panel_next.startup_power_fail_led = COL_YELLOW;
        end
        if (ctrl_reg.backup_done) begin
          panel_next.run = COL_GREEN;
        end
        if (!upg_fin_reg && ctrl_reg.upg_busy) begin
          panel_next.system_fault_led = flash(COL_GREEN, slow_ph_reg);
        end
        if (hold_s) begin
          display_next.seg = SEG_EIGHT;
        end else if (mode_reg == MODE_RUN) begin
          display_next.seg = SEG_SIX;
        end else begin
          display_next.seg = SEG_BLANK;
        end
        display_next.dp = ctrl_reg.drv_comm && slow_ph_reg;
      end
    endcase
  end

  // Registered panel, display and processor controls.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      panel_reg <= '0;
      display_reg <= '0;
      halt_reg <= 1'b0;
      cpu_rst_reg <= 1'b0;
      low_pwr_reg <= 1'b0;
    end else begin
      panel_reg <= panel_next;
      display_reg <= display_next;
      halt_reg <= (mode_reg == MODE_FAULT);
      cpu_rst_reg <= (mode_reg == MODE_PERM) || hold_s;
      low_pwr_reg <= (mode_reg == MODE_PERM);
    end
  end

  // Network interface LEDs; link and activity are per port.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_reg <= '0;
      act_reg <= '0;
      net_fault_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      link_reg <= link_s;
      act_reg <= busy_s & {NPORTS{fast_ph_reg}};
      if (bus_flt_s) begin
        net_fault_reg <= 1'b1;
      end else if (dev_fail_s) begin
        net_fault_reg <= slow_ph_reg;
      end else begin
        net_fault_reg <= 1'b0;
      end
      if (!ctrl_reg.iso_cfg || !locked_s) begin
        sync_reg <= 1'b0;
      end else begin
        sync_reg <= drv_sync_s || slow_ph_reg;
      end
    end
  end

  // Cycle clock: no tick unless isochronous operation is configured; then follow the send cycle when locked, else run a local substitute.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_d_reg <= 1'b0;
      subst_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cyc_d_reg <= cyc_s;
      if (subst_cnt_reg == 32'(SUBST_CYCLE - 1)) begin
        subst_cnt_reg <= '0;
      end else begin
        subst_cnt_reg <= subst_cnt_reg + 32'h1;
      end
      if (!ctrl_reg.iso_cfg) begin
        tick_reg <= 1'b0;
      end else if (locked_s) begin
        tick_reg <= cyc_s && !cyc_d_reg;
      end else begin
        tick_reg <= (subst_cnt_reg == 32'h0);
      end
    end
  end

  // Read port: data stands only in the cycle after the strobe.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (rd_stb) begin
      case (addr)
        ADDR_CTRL: rdata_reg <= 32'(ctrl_reg);
        ADDR_STAT: rdata_reg <= {26'h0, upg_fin_reg, (copy_cnt_reg != 32'h0), hold_s,
                                 (mode_reg == MODE_POWERUP), (mode_reg == MODE_PERM),
                                 (mode_reg == MODE_FAULT)};
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata = rdata_reg;
  assign panel = panel_reg;
  assign display = display_reg;
  assign link_led = link_reg;
  assign port_activity_led = act_reg;
  assign net_fault_led = net_fault_reg;
  assign sync_led = sync_reg;
  assign cycle_tick = tick_reg;
  assign cpu_halt = halt_reg;
  assign cpu_reset = cpu_rst_reg;
  assign low_power = low_pwr_reg;
  assign boot_req = boot_reg;

  AST_BACKUP_YELLOW:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode_reg == MODE_RUN && ctrl_reg.backup_run) |=>
      (panel_reg.stop == COL_YELLOW && panel_reg.startup_power_fail_led == COL_YELLOW))
    else $error("Backup indication missing.");

  AST_BACKUP_DONE:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode_reg == MODE_RUN && ctrl_reg.backup_done) |=> panel_reg.run == COL_GREEN)
    else $error("Backup done indication missing.");

  AST_COPY_HOLD:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      copy_ok_wr |=> copy_cnt_reg == 32'(COPY_HOLD) ##1
      (copy_cnt_reg == 32'(COPY_HOLD - 1) || $past(copy_ok_wr)))
    else $error("Copy hold timer not loaded.");

  AST_FAULT_SHOW:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      mode_reg == MODE_FAULT |=> (display_reg.seg == SEG_F && halt_reg))
    else $error("Fault hold display wrong.");

  AST_LATCHED:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode_reg == MODE_FAULT || mode_reg == MODE_PERM) |=> $stable(mode_reg))
    else $error("Latched state left.");

  AST_PERM:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      mode_reg == MODE_PERM |=> (cpu_rst_reg && low_pwr_reg && display_reg.seg == SEG_EIGHT))
    else $error("Permanent reset outputs wrong.");

  AST_BUS_FAULT:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      bus_flt_s [*2] |=> net_fault_reg)
    else $error("Bus fault LED not steady.");

  AST_SYNC_OFF:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!ctrl_reg.iso_cfg || !locked_s) |=> !sync_reg)
    else $error("Sync LED lit without lock.");

  AST_BLINK:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      slow_cnt_reg == 32'(BLINK_HALF - 1) |=> (slow_ph_reg != $past(slow_ph_reg)))
    else $error("Blink phase did not toggle.");

  AST_SUBST:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      (ctrl_reg.iso_cfg && !locked_s && subst_cnt_reg == 32'h0) |=> tick_reg)
    else $error("Substitute cycle tick missing.");

endmodule

// file: test/sld_viewer.sv
// Operator's eye on one front-panel lamp: it records which colours it saw and how long the last
// and the longest steady run lasted. It assumes the bench picks the lamp and clears it on a clock edge.
`timescale 1ns/1ps
module sld_viewer (
  input wire logic ref_clk,
  input wire logic clr,
  input wire logic [1:0] lamp,
  output logic [3:0] seen,
  output int unsigned last_run,
  output int unsigned max_run,
  output int unsigned changes
);
  logic [1:0] prev_reg;
  int unsigned run_reg;

  // The first run after a clear is partial, so it never counts towards the longest run.
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      seen <= 4'h0;
      changes <= 0;
      max_run <= 0;
      last_run <= 0;
      run_reg <= 1;
    end else begin
      seen[lamp] <= 1'b1;
      if (lamp !== prev_reg) begin
        changes <= changes + 1;
        last_run <= run_reg;
        run_reg <= 1;
        if (run_reg > max_run && changes != 0) begin
          max_run <= run_reg;
        end
      end else begin
        run_reg <= run_reg + 1;
      end
    end
    prev_reg <= lamp;
  end
endmodule

// file: test/testbench.sv
// Self-checking bench for the status encoder, with shortened blink and hold counts.
// It assumes the viewer model watches one lamp, chosen by sel, on the same clock.
`timescale 1ns/1ps
module testbench;
  import sld_pkg::*;
  localparam int BH = 4;
  localparam int FH = 2;
  localparam int HOLD = 20;
  localparam int SUB = 8;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic reset_button = 1'b0, fan_fault = 1'b0, overtemp = 1'b0, bus_fault = 1'b0;
  logic device_fail = 1'b0, cycle_locked = 1'b0, drives_synced = 1'b0, ext_cycle = 1'b0;
  logic [1:0] port_link = 2'h0, port_busy = 2'h0, link_led, port_activity_led;
  sld_panel_t panel;
  sld_seg_t display;
  logic net_fault_led, sync_led, cycle_tick, cpu_halt, cpu_reset, low_power, boot_req;
  logic clr = 1'b1;
  logic [3:0] sel = 4'h0;
  logic [3:0] seen;
  logic [19:0] view_vec;
  int unsigned last_run, max_run, changes;
  int miscompares = 0;
  int checks_done = 0;
  int boot_pulses = 0;

  always #2.5 ref_clk = ~ref_clk;

  sld_encoder #(.NPORTS(2), .BLINK_HALF(BH), .FLICKER_HALF(FH), .COPY_HOLD(HOLD),
    .SUBST_CYCLE(SUB)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .reset_button(reset_button),
    .fan_fault(fan_fault), .overtemp(overtemp), .bus_fault(bus_fault),
    .device_fail(device_fail), .cycle_locked(cycle_locked), .drives_synced(drives_synced),
    .ext_cycle(ext_cycle), .port_link(port_link), .port_busy(port_busy), .panel(panel),
    .display(display), .link_led(link_led), .port_activity_led(port_activity_led),
    .net_fault_led(net_fault_led), .sync_led(sync_led), .cycle_tick(cycle_tick),
    .cpu_halt(cpu_halt), .cpu_reset(cpu_reset), .low_power(low_power), .boot_req(boot_req));

  // Lamp slots: 0 system fault, 1 startup, 2 stop, 3 run, 4 ready, 5 point, 6 activity,
  // 7 network fault, 8 sync, 9 cycle tick.
  assign view_vec = {1'b0, cycle_tick, 1'b0, sync_led, 1'b0, net_fault_led, 1'b0,
    port_activity_led[0], 1'b0, display.dp, panel};

  sld_viewer eye_u (.ref_clk(ref_clk), .clr(clr), .lamp(view_vec[{sel, 1'b0} +: 2]),
    .seen(seen), .last_run(last_run), .max_run(max_run), .changes(changes));

  // A boot request stands one cycle only, so it is counted at every edge.
  always @(posedge ref_clk) begin
    if (boot_req === 1'b1) boot_pulses++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // An idle edge follows every strobe, so no strobe is assigned twice in one time step.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    cyc(1);
    wr_stb <= 1'b0;
    cyc(1);
  endtask

  task automatic rd_check(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    addr <= a;
    rd_stb <= 1'b1;
    cyc(1);
    rd_stb <= 1'b0;
    #1 d = rdata;
    cyc(1);
    check(what, exp, d);
  endtask

  // Watch one lamp for n cycles from a clean start.
  task automatic watch(input logic [3:0] s, input int n);
    sel <= s;
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(n);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    cyc(12);
    rst_n <= 1'b1;
    cyc(1);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic t_powerup();
    watch(4'h2, 40);
    check("stop flash colours", 32'h5, seen);
    check("stop flash half", BH, last_run);
    rd_check("status powering", ADDR_STAT, 32'h4);
    wr(ADDR_CTRL, 32'h10);
    cyc(3);
    check("powered seg", SEG_SIX, display.seg);
    rd_check("ctrl readback", ADDR_CTRL, 32'h10);
    rd_check("cmd reads zero", ADDR_CMD, 32'h0);
    rd_check("unmapped read", 4'hc, 32'h0);
    $display("test powerup done");
  endtask

  task automatic t_backup_copy();
    wr(ADDR_CTRL, 32'h11);
    cyc(3);
    check("backup stop", COL_YELLOW, panel.stop);
    check("backup startup", COL_YELLOW, panel.startup_power_fail_led);
    wr(ADDR_CTRL, 32'h12);
    cyc(3);
    check("backup done run", COL_GREEN, panel.run);
    wr(ADDR_CTRL, 32'h14);
    watch(4'h4, 16);
    check("copy steady yellow", 32'h4, seen);
    wr(ADDR_CMD, 32'h1);
    cyc(2);
    for (int i = 0; i < HOLD - 4; i++) begin
      cyc(1);
      check("copy green", COL_GREEN, panel.rdy);
    end
    cyc(8);
    check("copy back yellow", COL_YELLOW, panel.rdy);
    $display("test backup and copy done");
  endtask

  task automatic t_upgrade();
    int boots;
    wr(ADDR_CTRL, 32'h18);
    cyc(3);
    watch(4'h0, 12);
    check("upgrade running led", 32'h3, seen);
    boots = boot_pulses;
    wr(ADDR_CMD, 32'h2);
    cyc(12);
    check("upgrade fault led", COL_OFF, panel.system_fault_led);
    check("boot pulses", 32'h1, boot_pulses - boots);
    $display("test upgrade done");
  endtask

  task automatic t_network();
    port_link <= 2'h1;
    port_busy <= 2'h1;
    cyc(6);
    check("link led", 32'h1, link_led);
    check("net fault idle", 32'h0, net_fault_led);
    watch(4'h6, 20);
    check("activity colours", 32'h3, seen);
    check("activity half", FH, last_run);
    check("idle port activity", 32'h0, port_activity_led[1]);
    bus_fault <= 1'b1;
    cyc(6);
    watch(4'h7, 12);
    check("bus fault steady", 32'h2, seen);
    bus_fault <= 1'b0;
    device_fail <= 1'b1;
    cyc(6);
    watch(4'h7, 30);
    check("device fail half", BH, last_run);
    device_fail <= 1'b0;
    port_link <= 2'h2;
    port_busy <= 2'h0;
    cyc(6);
    check("link led moved", 32'h2, link_led);
    $display("test network done");
  endtask

  task automatic t_sync();
    wr(ADDR_CTRL, 32'h50);
    watch(4'h9, 40);
    check("substitute tick gap", SUB - 1, max_run);
    watch(4'h8, 12);
    check("unlocked sync off", 32'h1, seen);
    cycle_locked <= 1'b1;
    cyc(6);
    watch(4'h8, 30);
    check("sync flash half", BH, last_run);
    drives_synced <= 1'b1;
    cyc(6);
    watch(4'h8, 12);
    check("sync steady", 32'h2, seen);
    ext_cycle <= 1'b1;
    watch(4'h9, 8);
    check("followed tick seen", 32'h3, seen);
    check("followed tick once", 32'h2, changes);
    ext_cycle <= 1'b0;
    wr(ADDR_CTRL, 32'h30);
    watch(4'h8, 12);
    check("unconfigured sync off", 32'h1, seen);
    watch(4'h5, 30);
    check("point flash half", BH, last_run);
    $display("test sync done");
  endtask

  task automatic t_hold_pins();
    for (int i = 0; i < 2; i++) begin
      {fan_fault, reset_button} <= 2'(1 << i);
      cyc(6);
      check("hold seg", SEG_EIGHT, display.seg);
      check("hold cpu reset", 32'h1, cpu_reset);
      {fan_fault, reset_button} <= 2'h0;
      cyc(6);
      check("hold released seg", SEG_SIX, display.seg);
    end
    $display("test hold pins done");
  endtask

  task automatic t_fault();
    wr(ADDR_CMD, 32'h4);
    cyc(2);
    check("fault seg", SEG_F, display.seg);
    check("fault halt", 32'h1, cpu_halt);
    watch(4'h4, 20);
    check("fault flicker colours", 32'h9, seen);
    check("fault flicker half", FH, last_run);
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      check("leds in phase", {5{panel.rdy}}, panel);
    end
    wr(ADDR_CTRL, 32'h10);
    cyc(4);
    check("fault latched", SEG_F, display.seg);
    rd_check("status fault", ADDR_STAT, 32'h21);
    do_reset();
    cyc(2);
    check("fault cleared", 32'h0, cpu_halt);
    wr(ADDR_CTRL, 32'h10);
    overtemp <= 1'b1;
    cyc(8);
    overtemp <= 1'b0;
    cyc(8);
    check("overtemp fault seg", SEG_F, display.seg);
    check("overtemp halt", 32'h1, cpu_halt);
    $display("test fault done");
  endtask

  task automatic t_perm();
    do_reset();
    wr(ADDR_CMD, 32'h8);
    cyc(2);
    check("perm seg", SEG_EIGHT, display.seg);
    check("perm cpu reset", 32'h1, cpu_reset);
    check("perm low power", 32'h1, low_power);
    watch(4'h4, 30);
    check("perm colours", 32'hc, seen);
    check("perm half", BH, last_run);
    wr(ADDR_CTRL, 32'h10);
    cyc(4);
    check("perm latched", 32'h1, low_power);
    do_reset();
    cyc(2);
    check("perm cleared", 32'h0, cpu_reset);
    $display("test permanent reset done");
  endtask

  initial begin
    do_reset();
    t_powerup();
    t_backup_copy();
    t_upgrade();
    t_network();
    t_sync();
    t_hold_pins();
    t_fault();
    t_perm();
    final_report();
  end

  // The tests take well under 2000 cycles; ten times that means a hang.
  initial begin
    cyc(20000);
    miscompares++;
    final_report();
  end
endmodule
